// file: include/dms_pkg.sv
package dms_pkg;

  localparam int unsigned CLK_HZ = 200_000_000;

  // Power-on hold time choices, in microseconds
  localparam longint unsigned HOLD_US_0 = 50_000;
  localparam longint unsigned HOLD_US_1 = 200_000;
  localparam longint unsigned HOLD_US_2 = 400_000;
  localparam longint unsigned HOLD_US_3 = 800_000;
  localparam longint unsigned HOLD_CYC_0 = HOLD_US_0 * (CLK_HZ / 1_000_000);
  localparam longint unsigned HOLD_CYC_1 = HOLD_US_1 * (CLK_HZ / 1_000_000);
  localparam longint unsigned HOLD_CYC_2 = HOLD_US_2 * (CLK_HZ / 1_000_000);
  localparam longint unsigned HOLD_CYC_3 = HOLD_US_3 * (CLK_HZ / 1_000_000);

  // Watchdog interval choices, in microseconds
  localparam longint unsigned WDOG_US_0 = 25_000;
  localparam longint unsigned WDOG_US_1 = 200_000;
  localparam longint unsigned WDOG_US_2 = 1_400_000;
  localparam longint unsigned WDOG_CYC_0 = WDOG_US_0 * (CLK_HZ / 1_000_000);
  localparam longint unsigned WDOG_CYC_1 = WDOG_US_1 * (CLK_HZ / 1_000_000);
  localparam longint unsigned WDOG_CYC_2 = WDOG_US_2 * (CLK_HZ / 1_000_000);

  // Manual reset debounce, in microseconds
  localparam longint unsigned DEBOUNCE_US = 10_000;
  localparam longint unsigned DEBOUNCE_CYC = DEBOUNCE_US * (CLK_HZ / 1_000_000);

  localparam int unsigned CNT_W = 32;

  typedef enum logic [1:0] {
    WDOG_SEL_SHORT = 2'h0,
    WDOG_SEL_MID = 2'h1,
    WDOG_SEL_LONG = 2'h2,
    WDOG_SEL_OFF = 2'h3
  } dms_wdog_sel_e;

  localparam logic [1:0] WDOG_SEL_RESET = 2'h3;

  typedef enum logic [2:0] {
    RST_HOLD = 3'b001,
    RST_COUNT = 3'b010,
    RST_RUN = 3'b100
  } dms_rst_state_e;

  // Comparator decisions from the analog front end
  typedef struct packed {
    logic mainBelowTrip;
    logic mainBelowBattery;
    logic secondBelowTrip;
  } dms_sense_s;

  // Open-drain pin: level out and enable
  typedef struct packed {
    logic out;
    logic oe;
  } dms_od_s;

endpackage

// file: rtl/dms_supervisor.sv
// How it works
// (RULE1) Reset held for selected power-on time
// (RULE2) Watchdog interval: three presets or off
// (RULE3) Fault asserts if no restart in interval
// (RULE4) Interval setting kept in nonvolatile store
// (RULE5) Reset while main supply below trip
// (RULE6) Second fail output follows comparator immediately
// (RULE7) Early low flag low while supply low
// (RULE8) Battery feeds backup only below both
// (RULE9) Manual reset input is debounced first
// (RULE10) Manual reset holds reset, then timeout
// (RULE11) Host restart is SDA fall plus stop; code restarts on any cycle with watchdogRestart high, no SDA decode
// (RULE12) Watchdog fault active low open drain
// (RULE13) Disabled setting never raises watchdog fault
`timescale 1ns/1ps

module dms_supervisor
  import dms_pkg::*;
#(
  parameter longint unsigned CYC_PER_MS = CLK_HZ / 1000
)
(
  input wire logic core_clk,
  input wire logic rst,
  input wire dms_sense_s sense,
  input wire logic manual_reset_n,
  input wire logic [1:0] holdSel,
  input wire logic watchdogRestart,
  input wire logic [1:0] nvWatchdogSel,
  input wire logic wdogSelWrite,
  input wire logic [1:0] wdogSelNew,
  output logic [1:0] nvWatchdogSelOut,
  output logic nvWatchdogSelWe,
  output logic systemReset,
  output dms_od_s watchdog_fault_n,
  output dms_od_s early_low_supply_n,
  output dms_od_s second_supply_fail_n,
  output logic backup_power_out
);

  // All timings scale from one timebase
  localparam longint unsigned HOLD_CYC_SEL0 = HOLD_US_0 * CYC_PER_MS / 1000;
  localparam longint unsigned HOLD_CYC_SEL1 = HOLD_US_1 * CYC_PER_MS / 1000;
  localparam longint unsigned HOLD_CYC_SEL2 = HOLD_US_2 * CYC_PER_MS / 1000;
  localparam longint unsigned HOLD_CYC_SEL3 = HOLD_US_3 * CYC_PER_MS / 1000;
  localparam longint unsigned WDOG_CYC_SEL0 = WDOG_US_0 * CYC_PER_MS / 1000;
  localparam longint unsigned WDOG_CYC_SEL1 = WDOG_US_1 * CYC_PER_MS / 1000;
  localparam longint unsigned WDOG_CYC_SEL2 = WDOG_US_2 * CYC_PER_MS / 1000;
  localparam longint unsigned DEBOUNCE_CYCLES = DEBOUNCE_US * CYC_PER_MS / 1000;

  function automatic logic [CNT_W-1:0] holdLimit(input logic [1:0] sel);
    case (sel)
      2'h0: holdLimit = CNT_W'(HOLD_CYC_SEL0);
      2'h1: holdLimit = CNT_W'(HOLD_CYC_SEL1);
      2'h2: holdLimit = CNT_W'(HOLD_CYC_SEL2);
      default: holdLimit = CNT_W'(HOLD_CYC_SEL3);
    endcase
  endfunction

  function automatic logic [CNT_W-1:0] wdogLimit(input logic [1:0] sel);
    case (sel)
      WDOG_SEL_SHORT: wdogLimit = CNT_W'(WDOG_CYC_SEL0);
      WDOG_SEL_MID: wdogLimit = CNT_W'(WDOG_CYC_SEL1);
      WDOG_SEL_LONG: wdogLimit = CNT_W'(WDOG_CYC_SEL2);
      default: wdogLimit = '0;
    endcase
  endfunction

  // Debounce of manual reset
  logic mrStable_q, mrStable_d;
  logic [CNT_W-1:0] dbCnt_q, dbCnt_d;

  always_comb
  begin
    mrStable_d = mrStable_q;
    dbCnt_d = '0;
    if (manual_reset_n != mrStable_q)
    begin
      dbCnt_d = dbCnt_q + CNT_W'(1);
      if (dbCnt_q >= CNT_W'(DEBOUNCE_CYCLES) - CNT_W'(1))
      begin
        mrStable_d = manual_reset_n; // RULE9
        dbCnt_d = '0;
      end
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      mrStable_q <= 1'b1;
      dbCnt_q <= '0;
    end
    else
    begin
      mrStable_q <= mrStable_d;
      dbCnt_q <= dbCnt_d;
    end
  end

  // Reset sequencer
  dms_rst_state_e rstState_q, rstState_d;
  logic [CNT_W-1:0] holdCnt_q, holdCnt_d;
  logic resetCause;

  assign resetCause = sense.mainBelowTrip || !mrStable_q; // RULE5 RULE10

  always_comb
  begin
    rstState_d = rstState_q;
    holdCnt_d = holdCnt_q;
    case (rstState_q)
      RST_HOLD:
      begin
        holdCnt_d = '0;
        if (!resetCause)
          rstState_d = RST_COUNT;
      end
      RST_COUNT:
      begin
        holdCnt_d = holdCnt_q + CNT_W'(1);
        if (resetCause)
          rstState_d = RST_HOLD;
        else if (holdCnt_q >= holdLimit(holdSel) - CNT_W'(1))
          rstState_d = RST_RUN; // RULE1
      end
      RST_RUN:
      begin
        holdCnt_d = '0;
        if (resetCause)
          rstState_d = RST_HOLD;
      end
      default: rstState_d = RST_HOLD;
    endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      rstState_q <= RST_HOLD;
      holdCnt_q <= '0;
    end
    else
    begin
      rstState_q <= rstState_d;
      holdCnt_q <= holdCnt_d;
    end
  end

  assign systemReset = (rstState_q != RST_RUN) || resetCause; // RULE5

  // Watchdog; setting lives in external nonvolatile store
  logic [CNT_W-1:0] wdCnt_q, wdCnt_d;
  logic wdFault_q, wdFault_d;
  logic wdOff;

  assign wdOff = (nvWatchdogSel == WDOG_SEL_OFF); // RULE13
  assign nvWatchdogSelOut = wdogSelNew; // RULE4
  assign nvWatchdogSelWe = wdogSelWrite; // RULE4

  always_comb
  begin
    wdCnt_d = wdCnt_q + CNT_W'(1);
    wdFault_d = wdFault_q;
    if (wdOff || systemReset || wdogSelWrite)
    begin
      wdCnt_d = '0;
      wdFault_d = 1'b0; // RULE13
    end
    else if (watchdogRestart) // RULE11
    begin
      wdCnt_d = '0;
      wdFault_d = 1'b0;
    end
    else if (wdCnt_q >= wdogLimit(nvWatchdogSel) - CNT_W'(1)) // RULE2
    begin
      wdCnt_d = wdCnt_q;
      wdFault_d = 1'b1; // RULE3
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      wdCnt_q <= '0;
      wdFault_q <= 1'b0;
    end
    else
    begin
      wdCnt_q <= wdCnt_d;
      wdFault_q <= wdFault_d;
    end
  end

  always_comb
  begin
    watchdog_fault_n.out = 1'b0;
    watchdog_fault_n.oe = wdFault_q; // RULE12
    early_low_supply_n.out = 1'b0;
    early_low_supply_n.oe = sense.mainBelowTrip; // RULE7
    second_supply_fail_n.out = 1'b0;
    second_supply_fail_n.oe = sense.secondBelowTrip; // RULE6
  end

  // High selects battery
  assign backup_power_out = sense.mainBelowTrip && sense.mainBelowBattery; // RULE8

  a_reset_on_low: assert property (@(posedge core_clk) disable iff (rst)
    sense.mainBelowTrip |-> systemReset) // RULE5
    else $error("reset not asserted with low supply");

  a_mr_holds_reset: assert property (@(posedge core_clk) disable iff (rst)
    !mrStable_q |-> systemReset) // RULE10
    else $error("reset not held during manual reset");

  a_release_after_hold: assert property (@(posedge core_clk) disable iff (rst)
    $fell(systemReset) |-> $past(rstState_q) == RST_COUNT) // RULE1
    else $error("reset released without hold time");

  a_wdog_off_quiet: assert property (@(posedge core_clk) disable iff (rst)
    wdOff |=> !watchdog_fault_n.oe) // RULE13
    else $error("watchdog fault while disabled");

  a_wdog_restart_clears: assert property (@(posedge core_clk) disable iff (rst)
    watchdogRestart |=> !watchdog_fault_n.oe) // RULE3
    else $error("restart did not clear fault");

  a_wdog_fires: assert property (@(posedge core_clk) disable iff (rst)
    (!wdOff && !systemReset && !watchdogRestart && !wdogSelWrite
     && wdCnt_q >= wdogLimit(nvWatchdogSel) - CNT_W'(1)) |=> watchdog_fault_n.oe) // RULE3
    else $error("watchdog fault missing on expiry");

  a_second_fail_now: assert property (@(posedge core_clk)
    second_supply_fail_n.oe == sense.secondBelowTrip) // RULE6
    else $error("second fail output lags comparator");

  a_early_low: assert property (@(posedge core_clk)
    early_low_supply_n.oe == sense.mainBelowTrip && early_low_supply_n.out == 1'b0) // RULE7
    else $error("early low flag wrong");

  a_battery_switch: assert property (@(posedge core_clk)
    backup_power_out |-> sense.mainBelowTrip && sense.mainBelowBattery) // RULE8
    else $error("battery selected wrongly");

  a_debounce_stable: assert property (@(posedge core_clk) disable iff (rst)
    $changed(mrStable_q) |-> mrStable_q == $past(manual_reset_n)) // RULE9
    else $error("debounced level does not match input");

endmodule

// file: tb/dms_host_model.sv
`timescale 1ns/1ps

module dms_host_model
(
  input wire logic core_clk,
  input wire logic systemReset,
  input wire logic kickOn,
  output logic watchdogRestart
);
  logic [3:0] gap_q;
  initial gap_q = 4'h0;
  initial watchdogRestart = 1'b0;
  // One restart every five cycles, none while held in reset
  always @(posedge core_clk)
  begin
    gap_q <= (gap_q == 4'h4) ? 4'h0 : gap_q + 4'h1;
    watchdogRestart <= #1 kickOn && !systemReset && (gap_q == 4'h0);
  end
endmodule

// file: tb/test_dms_supervisor.sv
`timescale 1ns/1ps

module test_dms_supervisor
  import dms_pkg::*;
;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  dms_sense_s sense = '0;
  logic manual_reset_n = 1'b1;
  logic [1:0] holdSel = 2'h0;
  logic [1:0] nvWatchdogSel = 2'h3;
  logic wdogSelWrite = 1'b0;
  logic [1:0] wdogSelNew = 2'h0;
  logic kickOn = 1'b0;
  logic watchdogRestart;
  logic [1:0] nvOut;
  logic nvWe;
  logic systemReset;
  logic backup;
  dms_od_s wdogOd;
  dms_od_s lowOd;
  dms_od_s secOd;
  int bad_count = 0;
  int cmp_count = 0;
  int n;
  // One cycle per millisecond keeps the run short
  localparam longint unsigned TB_CYC_PER_MS = 1;
  localparam int DB_LEN = int'(DEBOUNCE_US * TB_CYC_PER_MS / 1000);
  int holdLen[4] = '{int'(HOLD_US_0 * TB_CYC_PER_MS / 1000),
    int'(HOLD_US_1 * TB_CYC_PER_MS / 1000), int'(HOLD_US_2 * TB_CYC_PER_MS / 1000),
    int'(HOLD_US_3 * TB_CYC_PER_MS / 1000)};
  int wdogLen[3] = '{int'(WDOG_US_0 * TB_CYC_PER_MS / 1000),
    int'(WDOG_US_1 * TB_CYC_PER_MS / 1000), int'(WDOG_US_2 * TB_CYC_PER_MS / 1000)};

  dms_supervisor #(.CYC_PER_MS(TB_CYC_PER_MS)) dut (.core_clk(core_clk), .rst(rst),
    .sense(sense),
    .manual_reset_n(manual_reset_n), .holdSel(holdSel), .watchdogRestart(watchdogRestart),
    .nvWatchdogSel(nvWatchdogSel), .wdogSelWrite(wdogSelWrite), .wdogSelNew(wdogSelNew),
    .nvWatchdogSelOut(nvOut), .nvWatchdogSelWe(nvWe), .systemReset(systemReset),
    .watchdog_fault_n(wdogOd), .early_low_supply_n(lowOd),
    .second_supply_fail_n(secOd), .backup_power_out(backup));

  dms_host_model host (.core_clk(core_clk), .systemReset(systemReset), .kickOn(kickOn),
    .watchdogRestart(watchdogRestart));

  initial
  begin
    forever #2.5 core_clk = ~core_clk;
  end

  task automatic tick(input int k);
    repeat (k) @(posedge core_clk);
    #1;
  endtask

  task automatic chk(input logic ok, input string m);
    cmp_count++;
    if (ok !== 1'b1)
    begin
      bad_count++;
      $display("unexpected at %0t: %s", $time, m);
    end
  endtask

  task automatic countRel();
    n = 0;
    while (systemReset !== 1'b0 && n < 2000)
    begin
      tick(1);
      n++;
    end
  endtask

  task automatic testSupply();
    for (int s = 0; s < 4; s++)
    begin
      holdSel = s[1:0];
      sense.mainBelowTrip = 1'b1;
      tick(2);
      chk(systemReset === 1'b1 && lowOd === 2'b01, "supply low");
      sense.mainBelowTrip = 1'b0;
      countRel();
      chk(n >= holdLen[s] && n <= holdLen[s] + 2, "hold length");
      chk(lowOd.oe === 1'b0, "low flag kept");
    end
    $display("supply test done");
  endtask

  task automatic testComparators();
    for (int i = 0; i < 8; i++)
    begin
      sense = i[2:0];
      #1;
      chk(secOd.oe === i[0] && secOd.out === 1'b0, "second fail");
      chk(backup === (i[2] & i[1]), "backup source");
      tick(1);
    end
    sense = '0;
    tick(1);
    countRel();
    $display("comparator test done");
  endtask

  task automatic testWatchdog();
    for (int s = 0; s < 3; s++)
    begin
      nvWatchdogSel = s[1:0];
      kickOn = 1'b1;
      tick(60);
      chk(wdogOd.oe === 1'b0, "fault despite restarts");
      kickOn = 1'b0;
      n = 0;
      while (wdogOd.oe !== 1'b1 && n < wdogLen[s] + 10)
      begin
        tick(1);
        n++;
      end
      chk(n >= wdogLen[s] - 6 && n <= wdogLen[s] + 1, "interval");
      chk(wdogOd.out === 1'b0, "fault level");
      kickOn = 1'b1;
      tick(8);
      chk(wdogOd.oe === 1'b0, "restart clear");
    end
    nvWatchdogSel = 2'h3;
    kickOn = 1'b0;
    tick(120);
    chk(wdogOd.oe === 1'b0, "fault while off");
    $display("watchdog test done");
  endtask

  task automatic testManual();
    holdSel = 2'h0;
    manual_reset_n = 1'b0;
    tick(2);
    manual_reset_n = 1'b1;
    tick(8);
    chk(systemReset === 1'b0, "glitch passed");
    manual_reset_n = 1'b0;
    tick(30);
    chk(systemReset === 1'b1, "manual hold");
    manual_reset_n = 1'b1;
    countRel();
    chk(n >= DB_LEN + holdLen[0] && n <= DB_LEN + holdLen[0] + 3, "manual release");
    $display("manual test done");
  endtask

  task automatic testStore();
    wdogSelNew = 2'h2;
    wdogSelWrite = 1'b1;
    #1;
    chk(nvWe === 1'b1 && nvOut === 2'h2, "store write");
    tick(1);
    wdogSelWrite = 1'b0;
    // Store keeps what was written
    nvWatchdogSel = nvOut;
    #1;
    chk(nvWe === 1'b0, "store idle");
    tick(1);
    rst = 1'b1;
    tick(2);
    rst = 1'b0;
    countRel();
    n = 0;
    while (wdogOd.oe !== 1'b1 && n < wdogLen[2] + 10)
    begin
      tick(1);
      n++;
    end
    chk(n >= wdogLen[2] - 1 && n <= wdogLen[2] + 1, "setting lost over reset");
    $display("store test done");
  endtask

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  initial
  begin
    tick(4);
    rst = 1'b0;
    countRel();
    chk(n >= holdLen[0] && n <= holdLen[0] + 2, "power on hold");
    testSupply();
    testComparators();
    testWatchdog();
    testManual();
    testStore();
    finish_test();
  end

  initial
  begin
    #60000;
    bad_count++;
    finish_test();
  end
endmodule
